//--- svd_cfg.svh
`ifndef SVD_CFG_SVH
`define SVD_CFG_SVH
`define SVD_OPT_ADDR 20'h0_00C1
`define SVD_OPT_ALT_ADDR 20'h0_10C1
`define SVD_GRP_MSB 7
`define SVD_GRP_LSB 5
`define SVD_FIXED_BIT 4
`define SVD_FINE_MSB 3
`define SVD_FINE_LSB 2
`define SVD_MODE_MSB 1
`define SVD_MODE_LSB 0
`define SVD_LVL_RST_MODE 8'h81
`define SVD_LVL_IRQ_MODE 8'h01
`define SVD_LVL_IR_MODE 8'h00
`define SVD_LVL_MODE_BIT 7
`define SVD_LVL_LOW_BIT 0
`define SVD_OPT_DEFAULT 8'hFF
`endif

//--- svd_pkg.sv
package svd_pkg;
  typedef enum logic [1:0] {
    SVD_MODE_OFF,
    SVD_MODE_RESET,
    SVD_MODE_IRQ,
    SVD_MODE_IRQ_RESET
  } svd_mode_t;
endpackage

//--- svd_if.sv
`timescale 1ns/1ps
interface svd_if;
  logic [7:0] opt_byte;
  logic cmp_below;
  logic cmp_below_low;
  logic [3:0] thr_code;
  logic thr_low_sel;
  logic svd_reset_req;
  logic low_voltage_irq;
  logic detector_reset_cause_flag;
  logic below_threshold_flag;
  logic low_voltage_irq_mask;
  logic [7:0] detect_level_register;
  logic level_rewrite_enable;
  logic irq_mask_clear;
  modport dev (
    input opt_byte, cmp_below, cmp_below_low, irq_mask_clear,
    output thr_code, thr_low_sel, svd_reset_req, low_voltage_irq,
    output detector_reset_cause_flag, below_threshold_flag,
    output low_voltage_irq_mask, detect_level_register, level_rewrite_enable
  );
  modport sys (
    output opt_byte, cmp_below, cmp_below_low, irq_mask_clear,
    input thr_code, thr_low_sel, svd_reset_req, low_voltage_irq,
    input detector_reset_cause_flag, below_threshold_flag,
    input low_voltage_irq_mask, detect_level_register, level_rewrite_enable
  );
endinterface

//--- svd_sync.sv
`timescale 1ns/1ps
module svd_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic [1:0] s_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // reset to below so the detector starts held and sees no false edge
      s_q <= 2'h3;
    end else begin
      s_q <= {s_q[0], d};
    end
  end
  assign q = s_q[1];
endmodule // svd_sync

//--- svd_dev.sv
`timescale 1ns/1ps
`include "svd_cfg.svh"
module svd_dev (
  input wire logic clk,
  input wire logic rst_n,
  svd_if.dev port
);
  import svd_pkg::*;

  typedef struct packed {
    logic [7:0] opt;
    svd_mode_t mode;
    logic [3:0] thr_code;
    logic thr_low_sel;
    logic rst_req;
    logic irq;
    logic cause;
    logic below;
    logic mask;
    logic [7:0] level;
    logic rewrite_en;
    logic below_prev;
    logic irq_armed;
    logic loaded;
  } svd_dev_state_t;

  svd_dev_state_t s_q;
  svd_dev_state_t s_d;
  logic below_s;
  logic below_low_s;
  logic [2:0] grp;
  logic [1:0] fine;
  logic [1:0] msel;
  logic [7:0] opt_mux;
  logic [1:0] cmp_raw;
  logic [1:0] cmp_s;

  ////////////////////////////////////////////////////////////////////
  // comparator levels: bit 0 upper, bit 1 lower
  assign cmp_raw = {port.cmp_below_low, port.cmp_below};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    svd_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(cmp_raw[i]),
      .q(cmp_s[i])
    );
  end
  assign below_s = cmp_s[0];
  assign below_low_s = cmp_s[1];

  ////////////////////////////////////////////////////////////////////
  // live byte until loaded, stored copy after
  // decoding the live byte lets the first cycle already run in the right mode
  assign opt_mux = s_q.loaded ? s_q.opt : port.opt_byte;

  ////////////////////////////////////////////////////////////////////
  // field decode
  assign grp = opt_mux[`SVD_GRP_MSB:`SVD_GRP_LSB];
  assign fine = opt_mux[`SVD_FINE_MSB:`SVD_FINE_LSB];
  assign msel = opt_mux[`SVD_MODE_MSB:`SVD_MODE_LSB];

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.below_prev = below_s;
    if (grp[2] && msel[0]) begin
      s_d.mode = SVD_MODE_OFF;
    end else begin
      case (msel)
        2'b11: s_d.mode = SVD_MODE_RESET;
        2'b01: s_d.mode = SVD_MODE_IRQ;
        2'b10: s_d.mode = SVD_MODE_IRQ_RESET;
        default: s_d.mode = SVD_MODE_OFF;
      endcase
    end
    // option byte load and per-mode level init, once after reset
    if (!s_q.loaded) begin
      s_d.loaded = 1'b1;
      s_d.opt = port.opt_byte;
      s_d.rewrite_en = 1'b0;
      case (s_d.mode)
        SVD_MODE_RESET: begin
          s_d.level = `SVD_LVL_RST_MODE;
        end
        SVD_MODE_IRQ: begin
          s_d.level = `SVD_LVL_IRQ_MODE;
        end
        default: begin
          s_d.level = `SVD_LVL_IR_MODE;
        end
      endcase
    end
    // group lower, fine upper
    // interrupt-reset mode: group picks the lower level, fine the upper one
    // group bits 1:0 and fine form threshold code
    s_d.thr_code = {grp[1:0], fine};
    // lower level selected by level register bit 0: set in reset and interrupt modes, clear in irq-reset mode
    s_d.thr_low_sel = s_q.level[`SVD_LVL_LOW_BIT];
    if (port.irq_mask_clear) begin
      s_d.mask = 1'b0;
    end
    case (s_d.mode)
      SVD_MODE_RESET: begin
        s_d.rst_req = below_s;
      end
      SVD_MODE_IRQ: begin
        if (!below_s) begin
          s_d.rst_req = 1'b0;
        end
        // irq on rising crossing after release
        if (!s_q.rst_req && s_q.below_prev && !below_s) begin
          s_d.irq = 1'b1;
        end
      end
      SVD_MODE_IRQ_RESET: begin
        // upper releases, lower asserts, falling upper interrupts
        if (below_low_s) begin
          s_d.rst_req = 1'b1;
        end else if (!below_s) begin
          s_d.rst_req = 1'b0;
          s_d.irq_armed = 1'b1;
        end
        if (!s_q.rst_req && s_q.irq_armed && below_s && !s_q.below_prev) begin
          s_d.irq = 1'b1;
          s_d.irq_armed = 1'b0;
        end
      end
      default: begin
        s_d.rst_req = 1'b0;
      end
    endcase
    // cause flag set by detector reset
    // only a fresh assertion counts, not the hold carried over from reset
    if (s_d.rst_req && !s_q.rst_req) begin
      s_d.cause = 1'b1;
    end
    s_d.below = (s_d.mode != SVD_MODE_OFF) && below_s;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.opt <= `SVD_OPT_DEFAULT;
      s_q.mode <= SVD_MODE_OFF;
      s_q.thr_code <= 4'h0;
      s_q.thr_low_sel <= 1'b0;
      s_q.rst_req <= 1'b1;
      s_q.irq <= 1'b0;
      s_q.cause <= 1'b0;
      s_q.below <= 1'b0;
      s_q.mask <= 1'b1;
      s_q.level <= `SVD_LVL_IR_MODE;
      s_q.rewrite_en <= 1'b0;
      s_q.below_prev <= 1'b1;
      s_q.irq_armed <= 1'b0;
      s_q.loaded <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign port.thr_code = s_q.thr_code;
  assign port.thr_low_sel = s_q.thr_low_sel;
  assign port.svd_reset_req = s_q.rst_req;
  assign port.low_voltage_irq = s_q.irq;
  assign port.detector_reset_cause_flag = s_q.cause;
  assign port.below_threshold_flag = s_q.below;
  assign port.low_voltage_irq_mask = s_q.mask;
  assign port.detect_level_register = s_q.level;
  assign port.level_rewrite_enable = s_q.rewrite_en;
endmodule // svd_dev

//--- svd_sys.sv
`timescale 1ns/1ps
module svd_sys (
  input wire logic clk,
  input wire logic rst_n,
  svd_if.sys port,
  input wire logic [7:0] user_opt_byte,
  input wire logic vdd_below_upper,
  input wire logic vdd_below_lower,
  input wire logic sw_mask_clear,
  output logic chip_reset_req,
  output logic irq_seen,
  output logic [7:0] level_seen
);
  typedef struct packed {
    logic rst;
    logic irq;
    logic [7:0] level;
  } svd_sys_state_t;
  svd_sys_state_t s_q;
  svd_sys_state_t s_d;

  assign port.opt_byte = user_opt_byte | 8'h10;
  assign port.cmp_below = vdd_below_upper;
  assign port.cmp_below_low = vdd_below_lower;
  assign port.irq_mask_clear = sw_mask_clear;

  always_comb begin
    s_d = s_q;
    s_d.rst = port.svd_reset_req;
    s_d.irq = port.low_voltage_irq && !port.low_voltage_irq_mask;
    s_d.level = port.detect_level_register;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign chip_reset_req = s_q.rst;
  assign irq_seen = s_q.irq;
  assign level_seen = s_q.level;
endmodule // svd_sys

//--- svd_checker.sv
`timescale 1ns/1ps
module svd_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] opt_byte,
  input wire logic cmp_below,
  input wire logic cmp_below_low,
  input wire logic svd_reset_req,
  input wire logic low_voltage_irq,
  input wire logic detector_reset_cause_flag,
  input wire logic below_threshold_flag,
  input wire logic low_voltage_irq_mask,
  input wire logic [7:0] detect_level_register,
  input wire logic level_rewrite_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rm, im, ir, off;
  assign rm = !opt_byte[7] && opt_byte[1:0] == 2'b11;
  assign im = !opt_byte[7] && opt_byte[1:0] == 2'b01;
  assign ir = !opt_byte[7] && opt_byte[1:0] == 2'b10;
  assign off = opt_byte[7] && opt_byte[0];
  ////////////////////////////////////////
  sequence s_up;
    rst_n [*2];
  endsequence
  sequence s_low;
    cmp_below [*6];
  endsequence
  sequence s_high;
    !cmp_below [*6];
  endsequence
  chk_rst_level: assert property (s_up ##0 rm |-> detect_level_register == 8'h81 && !level_rewrite_enable)
    else $error("reset mode level wrong");
  chk_irq_level: assert property (s_up ##0 im |-> detect_level_register == 8'h01 && !level_rewrite_enable)
    else $error("interrupt mode level wrong");
  chk_low_resets: assert property (rm ##0 s_low |-> svd_reset_req && below_threshold_flag)
    else $error("no reset on low supply");
  chk_high_release: assert property ((rm || im || ir) ##0 s_high |-> !svd_reset_req)
    else $error("reset not released");
  chk_irq_pulse: assert property (low_voltage_irq |=> !low_voltage_irq)
    else $error("interrupt wider than one cycle");
  chk_irq_rise: assert property (im && !svd_reset_req ##1 $fell(cmp_below) |-> ##[1:5] low_voltage_irq)
    else $error("no interrupt on rising supply");
  chk_cause_set: assert property ($rose(svd_reset_req) |-> ##[0:2] detector_reset_cause_flag)
    else $error("cause flag not set");
  chk_mask_set: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=> low_voltage_irq_mask)
    else $error("mask not set by reset");
  chk_off_quiet: assert property (rst_n [*3] ##0 off |-> !svd_reset_req && !below_threshold_flag)
    else $error("detector active while off");
  chk_lower_resets: assert property (ir ##0 cmp_below_low [*6] |-> svd_reset_req)
    else $error("no reset on lower level");
endmodule // svd_checker

//--- tb_supply_voltage_detect_control.sv
`timescale 1ns/1ps
module tb_supply_voltage_detect_control;
  logic clk = 0, rst_n = 0, hi = 1, lo = 1, mclr = 0;
  logic [7:0] opt = 8'h1f;
  logic rreq, irq;
  logic [7:0] lvl;
  logic [2:0] obs;
  int error_cnt = 0, n_compared = 0;
  svd_if bus ();
  svd_dev svd_dev_i (.clk(clk), .rst_n(rst_n), .port(bus));
  svd_sys svd_sys_i (.clk(clk), .rst_n(rst_n), .port(bus), .user_opt_byte(opt),
    .vdd_below_upper(hi), .vdd_below_lower(lo), .sw_mask_clear(mclr),
    .chip_reset_req(rreq), .irq_seen(irq), .level_seen(lvl));
  svd_checker svd_checker_i (.clk(clk), .rst_n(rst_n), .opt_byte(bus.opt_byte),
    .cmp_below(bus.cmp_below), .cmp_below_low(bus.cmp_below_low),
    .svd_reset_req(bus.svd_reset_req), .low_voltage_irq(bus.low_voltage_irq),
    .detector_reset_cause_flag(bus.detector_reset_cause_flag),
    .below_threshold_flag(bus.below_threshold_flag),
    .low_voltage_irq_mask(bus.low_voltage_irq_mask),
    .detect_level_register(bus.detect_level_register),
    .level_rewrite_enable(bus.level_rewrite_enable));
  assign obs = {irq, bus.detector_reset_cause_flag, rreq};
  always #25 clk = ~clk;
  ////////////////////////////////////////
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // option byte is taken on the first clock after reset is released
  task start(input logic [7:0] b);
    opt = b;
    mclr = 0;
    rst_n = 0;
    cyc(4);
    rst_n = 1;
    cyc(2);
  endtask
  task wt(input string nm, input int i, input logic v);
    int k;
    k = 0;
    while (obs[i] !== v && k < 20) begin
      cyc(1);
      k++;
    end
    cmp(nm, 8'(v), 8'(obs[i]));
    if (k == 20) end_of_test();
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(1);
    start(8'h1f);
    cmp("level", 8'h81, lvl);
    cmp("rewrite", 8'h00, 8'(bus.level_rewrite_enable));
    cmp("mask", 8'h01, 8'(bus.low_voltage_irq_mask));
    cmp("held", 8'h01, 8'(rreq));
    cmp("cause", 8'h00, 8'(bus.detector_reset_cause_flag));
    cmp("thr", 8'h03, 8'(bus.thr_code));
    cmp("low sel", 8'h01, 8'(bus.thr_low_sel));
    {hi, lo} = 2'b00;
    wt("release", 0, 1'b0);
    {hi, lo} = 2'b11;
    wt("reset", 0, 1'b1);
    wt("cause", 1, 1'b1);
    cmp("below", 8'h01, 8'(bus.below_threshold_flag));
    start(8'h1d);
    cmp("level", 8'h01, lvl);
    cmp("rewrite", 8'h00, 8'(bus.level_rewrite_enable));
    cmp("held", 8'h01, 8'(rreq));
    {hi, lo} = 2'b00;
    wt("release", 0, 1'b0);
    mclr = 1;
    {hi, lo} = 2'b11;
    cyc(6);
    cmp("mask", 8'h00, 8'(bus.low_voltage_irq_mask));
    cmp("no reset", 8'h00, 8'(rreq));
    {hi, lo} = 2'b00;
    wt("irq", 2, 1'b1);
    start(8'h91);
    {hi, lo} = 2'b11;
    cyc(6);
    cmp("off reset", 8'h00, 8'(rreq));
    cmp("off below", 8'h00, 8'(bus.below_threshold_flag));
    start(8'h1a);
    cmp("level", 8'h00, lvl);
    cmp("thr", 8'h02, 8'(bus.thr_code));
    cmp("low sel", 8'h00, 8'(bus.thr_low_sel));
    {hi, lo} = 2'b00;
    wt("release", 0, 1'b0);
    mclr = 1;
    cyc(4);
    {hi, lo} = 2'b10;
    wt("irq", 2, 1'b1);
    cmp("upper only", 8'h00, 8'(rreq));
    {hi, lo} = 2'b11;
    wt("reset", 0, 1'b1);
    end_of_test();
  end
endmodule // tb_supply_voltage_detect_control
